// File: hdl/dcf_fifo_flags.sv
// FIFO with synchronized empty, almost-empty, almost-full and full flags
module dcf_fifo_flags
    import dcf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Write port
    input wire logic wrEnable,
    input wire logic [DATA_W-1:0] wrData,
    output logic fullFlagN,
    output logic almostFullN,
    // Read port
    input wire logic rdEnable,
    output logic [DATA_W-1:0] rdData,
    output logic emptyFlagN,
    output logic almostEmptyN,
    // Serial offset loading
    input wire logic serialEnable,
    input wire logic serialData
);

    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [PTR_W-1:0] wrPtr, next_wrPtr, wrGray, next_wrGray;
    logic [PTR_W-1:0] rdPtr, next_rdPtr, rdGray, next_rdGray;
    logic [PTR_W-1:0] wrSync1, wrSync2, rdSync1, rdSync2;
    logic [DATA_W-1:0] next_rdData;
    dcf_out_e outState, next_outState;
    logic fallThroughMode, next_fallThroughMode;
    logic [ADDR_W-1:0] aeOffset, next_aeOffset, afOffset, next_afOffset;
    logic [SERIAL_BITS-1:0] serialShift, next_serialShift;
    logic [4:0] serialCount, next_serialCount;
    logic [31:0] next_prdata;

    logic [PTR_W-1:0] rdCount, wrCount, wrFree;
    logic wrAccept, rdAccept, outLoad;
    dcf_levels_s levels;
    dcf_flags_s flags;

    // ----------------------------------------------------------------
    // Comparators
    // ----------------------------------------------------------------
    // Both counts use only the second synchronizer stage of the far pointer
    always_comb begin
        rdCount = PTR_W'(dcf_gray2bin(wrSync2) - rdPtr);
        wrCount = PTR_W'(wrPtr - dcf_gray2bin(rdSync2));
        wrFree = PTR_W'(DEPTH - wrCount);
        levels.emptyLevel = dcf_level(rdCount, PTR_ZERO);
        levels.fullLevel = dcf_level(wrFree, PTR_ZERO);
        levels.aeLevel = dcf_level(rdCount, PTR_W'(aeOffset));
        levels.afLevel = dcf_level(wrFree, PTR_W'(afOffset));
    end

    // ----------------------------------------------------------------
    // Flags
    // ----------------------------------------------------------------
    // Flags lag the far event by two synchronizer edges; the fall-through empty flag follows outState and lags by three
    always_comb begin
        flags.fullFlagN = levels.fullLevel != 2'h0;
        flags.almostFullN = levels.afLevel != 2'h0;
        flags.almostEmptyN = levels.aeLevel != 2'h0;
        if (fallThroughMode) begin
            flags.emptyFlagN = outState == OUT_FRESH;
        end else begin
            flags.emptyFlagN = levels.emptyLevel != 2'h0;
        end
        fullFlagN = flags.fullFlagN;
        almostFullN = flags.almostFullN;
        almostEmptyN = flags.almostEmptyN;
        emptyFlagN = flags.emptyFlagN;
    end

    // ----------------------------------------------------------------
    // Write side
    // ----------------------------------------------------------------
    // Writes while full are dropped; Gray copy is registered so it never glitches
    always_comb begin
        wrAccept = wrEnable && flags.fullFlagN;
        next_wrPtr = wrAccept ? PTR_W'(wrPtr + PTR_ONE) : wrPtr;
        next_wrGray = dcf_bin2gray(next_wrPtr);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrPtr <= PTR_ZERO;
            wrGray <= PTR_ZERO;
        end else begin
            wrPtr <= next_wrPtr;
            wrGray <= next_wrGray;
        end
    end

    // Memory array holds no reset; only written locations are ever read
    always_ff @(posedge sys_clk) begin
        if (wrAccept) begin
            mem[wrPtr[ADDR_W-1:0]] <= wrData;
        end
    end

    // ----------------------------------------------------------------
    // Pointer synchronizers
    // ----------------------------------------------------------------
    // Two stages each way; an event one edge before a sampling edge meets the
    // skew window, so the next edge is the first synchronization cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrSync1 <= PTR_ZERO;
            wrSync2 <= PTR_ZERO;
            rdSync1 <= PTR_ZERO;
            rdSync2 <= PTR_ZERO;
        end else begin
            wrSync1 <= wrGray;
            wrSync2 <= wrSync1;
            rdSync1 <= rdGray;
            rdSync2 <= rdSync1;
        end
    end

    // ----------------------------------------------------------------
    // Read side and output register
    // ----------------------------------------------------------------
    // Fall-through loads unrequested once a word is visible: write edge plus three
    always_comb begin
        next_outState = outState;
        if (fallThroughMode) begin
            rdAccept = rdEnable && (outState == OUT_FRESH);
            outLoad = (levels.emptyLevel != 2'h0) && ((outState == OUT_STALE) || rdAccept);
            case ({outLoad, rdAccept})
                2'b10, 2'b11: next_outState = OUT_FRESH;
                2'b01: next_outState = OUT_STALE;
                default: next_outState = outState;
            endcase
        end else begin
            rdAccept = rdEnable && flags.emptyFlagN;
            outLoad = rdAccept;
            next_outState = OUT_STALE;
        end
        next_rdPtr = outLoad ? PTR_W'(rdPtr + PTR_ONE) : rdPtr;
        next_rdGray = dcf_bin2gray(next_rdPtr);
        next_rdData = outLoad ? mem[rdPtr[ADDR_W-1:0]] : rdData;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdPtr <= PTR_ZERO;
            rdGray <= PTR_ZERO;
            outState <= OUT_STALE;
            rdData <= '0;
        end else begin
            rdPtr <= next_rdPtr;
            rdGray <= next_rdGray;
            outState <= next_outState;
            rdData <= next_rdData;
        end
    end

    // ----------------------------------------------------------------
    // Registers and offset programming
    // ----------------------------------------------------------------
    logic apbSetup, apbWrite, addrHit;

    // Zero wait states; read data is captured in the setup cycle so it comes from a flop
    always_comb begin
        apbSetup = psel && !penable;
        apbWrite = psel && penable && pwrite;
        addrHit = (paddr == REG_CTRL) || (paddr == REG_AE_OFFSET) ||
                  (paddr == REG_AF_OFFSET) || (paddr == REG_STATUS);
        pready = psel && penable;
        pslverr = psel && penable && !addrHit;
        next_fallThroughMode = fallThroughMode;
        next_aeOffset = aeOffset;
        next_afOffset = afOffset;
        next_serialShift = serialShift;
        next_serialCount = serialCount;
        next_prdata = prdata;
        // Serial stream carries almost-full offset first, then almost-empty
        if (serialEnable) begin
            next_serialShift = {serialShift[SERIAL_BITS-2:0], serialData};
            if (serialCount == SERIAL_LAST) begin
                next_afOffset = serialShift[SERIAL_BITS-2:ADDR_W-1];
                next_aeOffset = {serialShift[ADDR_W-2:0], serialData};
                next_serialCount = '0;
            end else begin
                next_serialCount = 5'(serialCount + 5'h01);
            end
        end
        // A bus write in the same cycle as the last serial bit wins
        if (apbWrite) begin
            case (paddr)
                REG_CTRL: next_fallThroughMode = pwdata[CTRL_FALL_THROUGH_MODE_BIT];
                REG_AE_OFFSET: next_aeOffset = pwdata[ADDR_W-1:0];
                REG_AF_OFFSET: next_afOffset = pwdata[ADDR_W-1:0];
                default: next_fallThroughMode = fallThroughMode;
            endcase
        end
        if (apbSetup) begin
            case (paddr)
                REG_CTRL: next_prdata = {31'h0, fallThroughMode};
                REG_AE_OFFSET: next_prdata = {21'h0, aeOffset};
                REG_AF_OFFSET: next_prdata = {21'h0, afOffset};
                REG_STATUS: next_prdata = {rdCount, levels, 8'h0, flags};
                default: next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fallThroughMode <= CTRL_RESET;
            aeOffset <= OFFSET_PRESET;
            afOffset <= OFFSET_PRESET;
            serialShift <= '0;
            serialCount <= '0;
            prdata <= 32'h0;
        end else begin
            fallThroughMode <= next_fallThroughMode;
            aeOffset <= next_aeOffset;
            afOffset <= next_afOffset;
            serialShift <= next_serialShift;
            serialCount <= next_serialCount;
            prdata <= next_prdata;
        end
    end

endmodule

// File: hdl/dcf_pkg.sv
// Constants, types and helpers shared by the FIFO status flag block
package dcf_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int DATA_W = 36;
    localparam int ADDR_W = 11;
    localparam int PTR_W = 12;
    localparam logic [PTR_W-1:0] DEPTH = 12'h800;
    localparam logic [PTR_W-1:0] PTR_ONE = 12'h001;
    localparam logic [PTR_W-1:0] PTR_TWO = 12'h002;
    localparam logic [PTR_W-1:0] PTR_ZERO = 12'h000;

    // ----------------------------------------------------------------
    // Offsets: preset at reset, serial load length
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFFSET_PRESET = 11'h008;
    localparam int SERIAL_BITS = 2 * ADDR_W;
    localparam logic [4:0] SERIAL_LAST = 5'h15;

    // ----------------------------------------------------------------
    // Register map (byte addresses) and field positions
    // ----------------------------------------------------------------
    localparam logic [31:0] REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] REG_AE_OFFSET = 32'h0000_0004;
    localparam logic [31:0] REG_AF_OFFSET = 32'h0000_0008;
    localparam logic [31:0] REG_STATUS = 32'h0000_000c;
    localparam int CTRL_FALL_THROUGH_MODE_BIT = 0;
    localparam logic CTRL_RESET = 1'b0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic {
        OUT_STALE = 1'b0,
        OUT_FRESH = 1'b1
    } dcf_out_e;

    typedef struct packed {
        logic fullFlagN;
        logic almostFullN;
        logic almostEmptyN;
        logic emptyFlagN;
    } dcf_flags_s;

    typedef struct packed {
        logic [1:0] afLevel;
        logic [1:0] fullLevel;
        logic [1:0] aeLevel;
        logic [1:0] emptyLevel;
    } dcf_levels_s;

    // Comparator level: 0 at or below threshold, 1 and 2 just above, 3 beyond
    function automatic logic [1:0] dcf_level(input logic [PTR_W-1:0] cnt, input logic [PTR_W-1:0] thr);
        logic [1:0] lvl;
        lvl = 2'h3;
        if (cnt <= thr) begin
            lvl = 2'h0;
        end else if (cnt == PTR_W'(thr + PTR_ONE)) begin
            lvl = 2'h1;
        end else if (cnt == PTR_W'(thr + PTR_TWO)) begin
            lvl = 2'h2;
        end
        return lvl;
    endfunction

    function automatic logic [PTR_W-1:0] dcf_bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] dcf_gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = g;
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// File: verif/dcf_flags_props.sv
// Flag timing checker for the FIFO flag block
module dcf_flags_props
    import dcf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic wrEnable,
    input wire logic rdEnable,
    input wire logic [DATA_W-1:0] rdData,
    input wire logic fullFlagN,
    input wire logic almostFullN,
    input wire logic emptyFlagN,
    input wire logic almostEmptyN
);
    timeunit 1ns;
    timeprecision 100ps;
    // Accepted transfers on each port, so the past-value checks look back at one signal
    wire logic wrTaken = wrEnable && fullFlagN;
    wire logic rdTaken = rdEnable && emptyFlagN;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // No write in the last three cycles, so an empty flag means memory is empty
    sequence quietWrite;
        !$past(wrEnable) && !$past(wrEnable, 2) && !$past(wrEnable, 3);
    endsequence
    apb_ready_a: assert property (pready == (psel && penable)) else $error("pready off the access phase");
    reset_flags_a: assert property ($fell(rst) |-> fullFlagN && almostFullN && !emptyFlagN && !almostEmptyN)
        else $error("flags wrong after reset");
    empty_early_a: assert property (!emptyFlagN && wrEnable && fullFlagN ##0 quietWrite |=> !emptyFlagN [*2])
        else $error("empty flag rose too early");
    empty_rise_a: assert property ($rose(emptyFlagN) |-> $past(wrEnable, 3) || $past(wrEnable, 4))
        else $error("empty flag rose without a synced write");
    full_rise_a: assert property ($rose(fullFlagN) |-> $past(rdTaken, 3))
        else $error("full flag rose off the second edge");
    af_rise_a: assert property ($rose(almostFullN) |-> $past(rdTaken, 3))
        else $error("almost-full rose off the second edge");
    ae_rise_a: assert property ($rose(almostEmptyN) |-> $past(wrTaken, 3))
        else $error("almost-empty rose off the second edge");
    rdata_hold_a: assert property (!emptyFlagN ##1 !emptyFlagN |-> $stable(rdData))
        else $error("output word changed while flag low");
endmodule
bind dcf_fifo_flags dcf_flags_props u_props (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pready(pready), .wrEnable(wrEnable), .rdEnable(rdEnable), .rdData(rdData), .fullFlagN(fullFlagN),
    .almostFullN(almostFullN), .emptyFlagN(emptyFlagN), .almostEmptyN(almostEmptyN));

// File: verif/dcf_port_agent.sv
// Writer and reader standing on the two FIFO ports
module dcf_port_agent
    import dcf_pkg::*;
(
    input wire logic sys_clk,
    output logic wrEnable,
    output logic [DATA_W-1:0] wrData,
    output logic rdEnable
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DATA_W-1:0] nextWord = 36'h100;
    initial begin
        wrEnable = 1'b0;
        wrData = 36'h0;
        rdEnable = 1'b0;
    end
    // Back-to-back writes; idle data is inverted so a stale word never looks valid
    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            wrEnable <= 1'b1;
            wrData <= nextWord;
            nextWord <= nextWord + 36'h1;
            @(posedge sys_clk);
        end
        wrEnable <= 1'b0;
        wrData <= ~wrData;
    endtask
    // Read request held for n edges
    task automatic pop(input int n);
        rdEnable <= 1'b1;
        repeat (n) @(posedge sys_clk);
        rdEnable <= 1'b0;
    endtask
endmodule

// File: verif/test_dcf_fifo_flags.sv
// Self-checking bench for the FIFO status flag block
module test_dcf_fifo_flags
    import dcf_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    // Given their first values by the main process, so no instance input starts out tied
    logic rst, psel, penable, pwrite, serialEnable, serialData;
    logic [31:0] paddr, pwdata;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, wrEnable, rdEnable, fullFlagN, almostFullN, emptyFlagN, almostEmptyN;
    logic [DATA_W-1:0] wrData, rdData;
    int fails = 0;
    int checks = 0;
    wire logic [3:0] flagVec = {fullFlagN, almostFullN, almostEmptyN, emptyFlagN};
    always #2.5 sys_clk = ~sys_clk;
    dcf_fifo_flags dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wrEnable(wrEnable), .wrData(wrData), .fullFlagN(fullFlagN), .almostFullN(almostFullN),
        .rdEnable(rdEnable), .rdData(rdData), .emptyFlagN(emptyFlagN), .almostEmptyN(almostEmptyN),
        .serialEnable(serialEnable), .serialData(serialData));
    dcf_port_agent agent (.sys_clk(sys_clk), .wrEnable(wrEnable), .wrData(wrData), .rdEnable(rdEnable));
    task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One APB transfer; an idle cycle follows so back-to-back calls never clash
    // Waits as long as the slave needs; only the watchdog ends a hung access
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Flag k sampled mid-cycle over n cycles, bit 0 of exp first
    task automatic watch(input int k, input logic [7:0] exp, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk);
            cmp(flagVec[k], exp[i]);
        end
        @(posedge sys_clk);
    endtask
    task automatic testStandard();
        apb(1'b0, REG_STATUS, 32'h0);
        cmp(rd[3:0], 4'hc);
        agent.push(1);
        watch(0, 8'b100, 3);
        agent.pop(1);
        watch(0, 8'b0, 1);
        cmp(rdData, 36'h100);
        agent.pop(1);
        watch(0, 8'b0, 1);
        cmp(rdData, 36'h100);
    endtask
    task automatic testAlmostEmpty();
        agent.push(9);
        watch(1, 8'b100, 3);
        agent.pop(1);
        watch(1, 8'b0, 1);
        cmp(rdData, 36'h101);
    endtask
    // Fill to the brim, try one refused write, then drain past both thresholds
    task automatic testFull();
        agent.push(2032);
        watch(2, 8'b0, 1);
        agent.push(8);
        watch(3, 8'b0, 1);
        repeat (4) @(posedge sys_clk);
        apb(1'b0, REG_STATUS, 32'h0);
        cmp(rd[31:20], 12'h800);
        agent.push(1);
        agent.pop(1);
        watch(3, 8'b100, 3);
        cmp(rdData, 36'h102);
        agent.pop(8);
        watch(2, 8'b100, 3);
        agent.pop(2039);
        watch(0, 8'b0, 1);
        cmp(rdData, 36'h901);
    endtask
    task automatic testFallThrough();
        apb(1'b1, REG_CTRL, 32'h1);
        agent.push(1);
        watch(0, 8'b1000, 4);
        cmp(rdData, 36'h903);
        agent.pop(1);
        watch(0, 8'b0, 1);
        cmp(rdData, 36'h903);
        // Two words: the first falls through, then a read pulls in the second at once
        agent.push(2);
        watch(0, 8'b1100, 4);
        cmp(rdData, 36'h904);
        agent.pop(1);
        watch(0, 8'b1, 1);
        cmp(rdData, 36'h905);
        agent.pop(1);
        watch(0, 8'b0, 1);
    endtask
    // Y then X, most significant bit first, one strobe per bit
    task automatic testSerial();
        logic [21:0] bits;
        bits = {11'h010, 11'h003};
        for (int i = 21; i >= 0; i--) begin
            serialEnable <= 1'b1;
            serialData <= bits[i];
            @(posedge sys_clk);
        end
        serialEnable <= 1'b0;
        @(posedge sys_clk);
        apb(1'b0, REG_AE_OFFSET, 32'h0);
        cmp(rd, 32'h3);
        apb(1'b0, REG_AF_OFFSET, 32'h0);
        cmp(rd, 32'h10);
        // Parallel programming over the bus overrides the serial values
        apb(1'b1, REG_AE_OFFSET, 32'h5);
        apb(1'b1, REG_AF_OFFSET, 32'h7);
        apb(1'b0, REG_AE_OFFSET, 32'h0);
        cmp(rd, 32'h5);
        apb(1'b0, REG_AF_OFFSET, 32'h0);
        cmp(rd, 32'h7);
        apb(1'b0, 32'h10, 32'h0);
        cmp({rd, err}, 33'h1);
    endtask
    // Watchdog: the whole run needs just over four thousand cycles
    initial begin
        #200000;
        fails++;
        summarize();
    end
    initial begin
        rst <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 32'h0;
        pwdata <= 32'h0;
        serialEnable <= 1'b0;
        serialData <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        testStandard();
        testAlmostEmpty();
        testFull();
        testFallThrough();
        testSerial();
        summarize();
    end
endmodule
